// ### design/bcrsc_pkg.sv
package bcrsc_pkg;

	// ****************
	// Instruction states and modes
	// ****************
	typedef enum logic [1:0] {
		BCRSC_ST_WIDE,
		BCRSC_ST_COMPACT,
		BCRSC_ST_BYTECODE
	} bcrsc_state_t;

	localparam logic [4:0] MODE_USER = 5'h10;
	localparam logic [4:0] MODE_FAST = 5'h11;
	localparam logic [4:0] MODE_IRQ = 5'h12;
	localparam logic [4:0] MODE_SUPER = 5'h13;
	localparam logic [4:0] MODE_ABORT = 5'h17;
	localparam logic [4:0] MODE_UNDEF = 5'h1B;
	localparam logic [4:0] MODE_SYSTEM = 5'h1F;

	// ****************
	// Status word layout
	// ****************
	localparam int SW_MODE_LSB = 0;
	localparam int SW_COMPACT_BIT = 5;
	localparam int SW_BYTECODE_BIT = 24;
	localparam int SW_FLAGS_LSB = 27;
	localparam logic [31:0] SW_RESET = 32'h0000_00D3;

	// Physical register file: 31 general, 6 status
	localparam int NUM_GP = 31;
	localparam int NUM_SAVED = 5;
	localparam logic [4:0] PHYS_FAST8 = 5'h10;
	localparam logic [4:0] PHYS_BANK13 = 5'h15;

	// Exception kinds, offsets and vectors
	typedef enum logic [2:0] {
		BCRSC_EX_NONE,
		BCRSC_EX_RESET,
		BCRSC_EX_DABORT,
		BCRSC_EX_FIQ,
		BCRSC_EX_IRQ,
		BCRSC_EX_PABORT,
		BCRSC_EX_UNDEF,
		BCRSC_EX_SWI
	} bcrsc_exc_t;

	localparam logic [31:0] VEC_UNDEF = 32'h0000_0004;
	localparam logic [31:0] VEC_SWI = 32'h0000_0008;
	localparam logic [31:0] VEC_PABORT = 32'h0000_000C;
	localparam logic [31:0] VEC_DABORT = 32'h0000_0010;
	localparam logic [31:0] VEC_IRQ = 32'h0000_0018;
	localparam logic [31:0] VEC_FAST = 32'h0000_001C;
	localparam logic [31:0] VEC_RESET = 32'h0000_0000;
	localparam logic [31:0] LINK_OFF_WIDE = 32'h0000_0004;
	localparam logic [31:0] LINK_OFF_COMPACT = 32'h0000_0002;
	localparam logic [31:0] LINK_OFF_DABORT = 32'h0000_0008;

	// Access sizes
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_HALF = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;

	// Bytecode decode cycles
	localparam logic [1:0] BC_DECODE_CYCLES = 2'h2;

endpackage

// ### design/bcrsc_regs_if.sv
`timescale 1ns/1ps
interface bcrsc_regs_if;
	logic [4:0] mode;
	logic [3:0] rd_a_idx;
	logic [3:0] rd_b_idx;
	logic [31:0] rd_a_data;
	logic [31:0] rd_b_data;
	logic wr_en;
	logic [3:0] wr_idx;
	logic [31:0] wr_data;
	logic link_en;
	logic [4:0] link_mode;
	logic [31:0] link_data;
	modport core (
		output mode, rd_a_idx, rd_b_idx, wr_en, wr_idx, wr_data,
		output link_en, link_mode, link_data,
		input rd_a_data, rd_b_data
	);
	modport bank (
		input mode, rd_a_idx, rd_b_idx, wr_en, wr_idx, wr_data,
		input link_en, link_mode, link_data,
		output rd_a_data, rd_b_data
	);
endinterface

// ### design/bcrsc_bank.sv
`timescale 1ns/1ps
module bcrsc_bank (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Core side
	bcrsc_regs_if.bank rf
);

	// ****************
	// Physical map
	// ****************
	// 0..15 shared r0-r14 (r15 kept by core), 16..20 fast r8-r12,
	// 21..30 pairs r13/r14 for fast, irq, super, abort, undef
	logic [31:0] gp_r [0:bcrsc_pkg::NUM_GP-1];

	function automatic logic [4:0] phys(input logic [4:0] m, input logic [3:0] idx);
		logic [4:0] pair;
		pair = 5'h0;
		case (m)
			bcrsc_pkg::MODE_FAST: pair = 5'h0;
			bcrsc_pkg::MODE_IRQ: pair = 5'h2;
			bcrsc_pkg::MODE_SUPER: pair = 5'h4;
			bcrsc_pkg::MODE_ABORT: pair = 5'h6;
			bcrsc_pkg::MODE_UNDEF: pair = 5'h8;
			default: pair = 5'h0;
		endcase
		// No banking in user or system
		if (m == bcrsc_pkg::MODE_USER || m == bcrsc_pkg::MODE_SYSTEM) begin
			phys = {1'b0, idx};
		end else if (idx >= 4'hD && idx <= 4'hE) begin
			phys = bcrsc_pkg::PHYS_BANK13 + pair + {4'h0, idx[0] ^ 1'b1};
		end else if (m == bcrsc_pkg::MODE_FAST && idx >= 4'h8 && idx <= 4'hC) begin
			phys = bcrsc_pkg::PHYS_FAST8 + {1'b0, idx} - 5'h8;
		end else begin
			phys = {1'b0, idx};
		end
	endfunction

	// Write port wins over link port on the same physical slot
	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < bcrsc_pkg::NUM_GP; i++) begin
				gp_r[i] <= 32'h0000_0000;
			end
		end else begin
			if (rf.link_en) begin
				gp_r[phys(rf.link_mode, 4'hE)] <= rf.link_data;
			end
			if (rf.wr_en && rf.wr_idx != 4'hF) begin
				gp_r[phys(rf.mode, rf.wr_idx)] <= rf.wr_data;
			end
		end
	end

	assign rf.rd_a_data = gp_r[phys(rf.mode, rf.rd_a_idx)];
	assign rf.rd_b_data = gp_r[phys(rf.mode, rf.rd_b_idx)];

endmodule

// ### design/bcrsc_core.sv
`timescale 1ns/1ps
// How it works
// - Wide, compact and bytecode states
// - Bytecode fetches whole words
// - Exchange or pc load outside bytecode picks compact from target bit 0
// - Bytecode branch from wide or exception return enters bytecode
// - Exceptions run in wide state
// - Return restores saved state
// - Five one-cycle stages
// - Bytecode decode takes two cycles
// - Access size alignment
// - Hazards stall or forward
// - Interrupts leave bytecode, restartable
// - Seven modes
// - Aborts, undefined enter own modes
// - Non-user modes privileged
// - 31 general, 6 status registers
// - Fast banks r8-r14, others r13-r14
// - Link branches write r14
// - Exceptions write banked r14
// - Exception modes save status
// - r15 is pc; one status word
// - Compact reaches r0-r7, sp, lr, pc
// - System shares user registers
// - Five-bit mode field, bytecode bit
// - Entry: link, save, mode, vector
module bcrsc_core (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Instruction issue from decode
	input wire logic op_valid,
	input wire logic [3:0] op_rd,
	input wire logic [3:0] op_rn,
	input wire logic [3:0] op_rm,
	input wire logic op_writes_rd,
	input wire logic [31:0] op_result,
	input wire logic op_is_load,
	input wire logic op_branch_exchange,
	input wire logic op_branch_link_exchange,
	input wire logic op_branch_with_link,
	input wire logic op_branch_to_bytecode,
	input wire logic [31:0] op_target,
	input wire logic op_status_write,
	input wire logic [31:0] op_status_data,
	input wire logic op_exc_return,
	input wire logic op_swi,
	input wire logic op_undef,
	// Exception sources
	input wire logic fast_irq,
	input wire logic normal_irq,
	input wire logic data_abort,
	input wire logic prefetch_abort,
	// Memory access request
	input wire logic mem_req,
	input wire logic [31:0] mem_addr,
	input wire logic [1:0] mem_size,
	output logic mem_misaligned,
	// Fetch port
	output logic [31:0] fetch_addr,
	output logic [1:0] fetch_size,
	// Operand and state view
	output logic [31:0] operand_a,
	output logic [31:0] operand_b,
	output logic stall,
	output logic [31:0] current_status_word,
	output logic [31:0] saved_status_word,
	output logic privileged,
	output logic [2:0] pipe_stage_valid,
	output logic op_illegal_reg
);

	// ****************
	// State
	// ****************
	bcrsc_regs_if rf();
	bcrsc_pkg::bcrsc_state_t state_r, state_nxt;
	logic [31:0] current_status_word_r;
	logic [31:0] saved_status_word_r [0:bcrsc_pkg::NUM_SAVED-1];
	logic [31:0] program_counter_r;
	logic [4:0] mode;
	logic [2:0] saved_status_word_idx;
	logic [31:0] link_ret;
	bcrsc_pkg::bcrsc_exc_t exc;
	logic [31:0] exc_vec;
	logic [4:0] exc_mode;
	logic irq_in_r [0:1][0:2];
	logic fast_s, norm_s;
	logic [31:0] status_restore;
	logic [1:0] bc_dec_cnt_r;
	logic [3:0] ex_rd_r, mem_rd_r;
	logic ex_wr_r, mem_wr_r, ex_load_r;
	logic [31:0] ex_val_r, mem_val_r;

	assign mode = current_status_word_r[bcrsc_pkg::SW_MODE_LSB +: 5];
	assign current_status_word = current_status_word_r;
	assign privileged = (mode != bcrsc_pkg::MODE_USER);

	// ****************
	// Interrupt input synchronisers
	// ****************
	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < 2; i++) begin
				for (int j = 0; j < 3; j++) begin
					irq_in_r[i][j] <= 1'b0;
				end
			end
			fast_s <= 1'b0;
			norm_s <= 1'b0;
		end else begin
			irq_in_r[0][0] <= fast_irq;
			irq_in_r[1][0] <= normal_irq;
			for (int i = 0; i < 2; i++) begin
				irq_in_r[i][1] <= irq_in_r[i][0];
				irq_in_r[i][2] <= irq_in_r[i][1];
			end
			if (irq_in_r[0][1] == irq_in_r[0][2]) begin
				fast_s <= irq_in_r[0][2];
			end
			if (irq_in_r[1][1] == irq_in_r[1][2]) begin
				norm_s <= irq_in_r[1][2];
			end
		end
	end

	// ****************
	// Exception selection by priority
	// ****************
	always_comb begin
		exc = bcrsc_pkg::BCRSC_EX_NONE;
		exc_vec = bcrsc_pkg::VEC_RESET;
		exc_mode = mode;
		if (data_abort) begin
			exc = bcrsc_pkg::BCRSC_EX_DABORT;
			exc_vec = bcrsc_pkg::VEC_DABORT;
			exc_mode = bcrsc_pkg::MODE_ABORT;
		end else if (fast_s) begin
			exc = bcrsc_pkg::BCRSC_EX_FIQ;
			exc_vec = bcrsc_pkg::VEC_FAST;
			exc_mode = bcrsc_pkg::MODE_FAST;
		end else if (norm_s) begin
			exc = bcrsc_pkg::BCRSC_EX_IRQ;
			exc_vec = bcrsc_pkg::VEC_IRQ;
			exc_mode = bcrsc_pkg::MODE_IRQ;
		end else if (op_valid && prefetch_abort) begin
			exc = bcrsc_pkg::BCRSC_EX_PABORT;
			exc_vec = bcrsc_pkg::VEC_PABORT;
			exc_mode = bcrsc_pkg::MODE_ABORT;
		end else if (op_valid && op_undef) begin
			exc = bcrsc_pkg::BCRSC_EX_UNDEF;
			exc_vec = bcrsc_pkg::VEC_UNDEF;
			exc_mode = bcrsc_pkg::MODE_UNDEF;
		end else if (op_valid && op_swi) begin
			exc = bcrsc_pkg::BCRSC_EX_SWI;
			exc_vec = bcrsc_pkg::VEC_SWI;
			exc_mode = bcrsc_pkg::MODE_SUPER;
		end
	end

	// Bytecode links the op itself so it restarts
	always_comb begin
		case (state_r)
			bcrsc_pkg::BCRSC_ST_COMPACT: link_ret = program_counter_r
				+ bcrsc_pkg::LINK_OFF_COMPACT;
			bcrsc_pkg::BCRSC_ST_BYTECODE: link_ret = program_counter_r;
			default: link_ret = program_counter_r + bcrsc_pkg::LINK_OFF_WIDE;
		endcase
		if (exc == bcrsc_pkg::BCRSC_EX_DABORT) begin
			link_ret = program_counter_r + bcrsc_pkg::LINK_OFF_DABORT;
		end
	end

	function automatic logic [2:0] saved_slot(input logic [4:0] m);
		case (m)
			bcrsc_pkg::MODE_FAST: saved_slot = 3'h0;
			bcrsc_pkg::MODE_IRQ: saved_slot = 3'h1;
			bcrsc_pkg::MODE_SUPER: saved_slot = 3'h2;
			bcrsc_pkg::MODE_ABORT: saved_slot = 3'h3;
			bcrsc_pkg::MODE_UNDEF: saved_slot = 3'h4;
			default: saved_slot = 3'h7;
		endcase
	endfunction

	assign saved_status_word_idx = saved_slot(mode);
	assign saved_status_word = (saved_status_word_idx == 3'h7) ? 32'h0000_0000 : saved_status_word_r[saved_status_word_idx];
	assign status_restore = saved_status_word;

	// ****************
	// Instruction state machine
	// ****************
	always_comb begin
		state_nxt = state_r;
		if (exc != bcrsc_pkg::BCRSC_EX_NONE) begin
			state_nxt = bcrsc_pkg::BCRSC_ST_WIDE;
		end else if (op_valid && !stall) begin
			if (op_exc_return && saved_status_word_idx != 3'h7) begin
				if (status_restore[bcrsc_pkg::SW_BYTECODE_BIT]) begin
					state_nxt = bcrsc_pkg::BCRSC_ST_BYTECODE;
				end else if (status_restore[bcrsc_pkg::SW_COMPACT_BIT]) begin
					state_nxt = bcrsc_pkg::BCRSC_ST_COMPACT;
				end else begin
					state_nxt = bcrsc_pkg::BCRSC_ST_WIDE;
				end
			end else if (op_branch_to_bytecode && state_r == bcrsc_pkg::BCRSC_ST_WIDE) begin
				state_nxt = bcrsc_pkg::BCRSC_ST_BYTECODE;
			end else if (state_r != bcrsc_pkg::BCRSC_ST_BYTECODE && (op_branch_exchange
				|| op_branch_link_exchange || (op_is_load && op_rd == 4'hF))) begin
				// Target bit 0 picks compact
				state_nxt = op_target[0] ? bcrsc_pkg::BCRSC_ST_COMPACT
					: bcrsc_pkg::BCRSC_ST_WIDE;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_r <= bcrsc_pkg::BCRSC_ST_WIDE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ****************
	// Status words
	// ****************
	always_ff @(posedge clk) begin
		if (reset) begin
			current_status_word_r <= bcrsc_pkg::SW_RESET;
		end else if (exc != bcrsc_pkg::BCRSC_EX_NONE) begin
			current_status_word_r[bcrsc_pkg::SW_MODE_LSB +: 5] <= exc_mode;
			current_status_word_r[bcrsc_pkg::SW_COMPACT_BIT] <= 1'b0;
			current_status_word_r[bcrsc_pkg::SW_BYTECODE_BIT] <= 1'b0;
		end else if (op_valid && !stall && op_exc_return && saved_status_word_idx != 3'h7) begin
			current_status_word_r <= status_restore;
		end else if (op_valid && !stall && op_status_write) begin
			current_status_word_r[31:bcrsc_pkg::SW_FLAGS_LSB] <= op_status_data[31:bcrsc_pkg::SW_FLAGS_LSB];
			if (privileged) begin
				current_status_word_r[bcrsc_pkg::SW_MODE_LSB +: 5] <= op_status_data[4:0];
			end
		end else begin
			current_status_word_r[bcrsc_pkg::SW_COMPACT_BIT] <= (state_nxt == bcrsc_pkg::BCRSC_ST_COMPACT);
			current_status_word_r[bcrsc_pkg::SW_BYTECODE_BIT] <= (state_nxt == bcrsc_pkg::BCRSC_ST_BYTECODE);
		end
	end

	// Saved words: one per exception mode
	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < bcrsc_pkg::NUM_SAVED; i++) begin
				saved_status_word_r[i] <= 32'h0000_0000;
			end
		end else if (exc != bcrsc_pkg::BCRSC_EX_NONE && saved_slot(exc_mode) != 3'h7) begin
			saved_status_word_r[saved_slot(exc_mode)] <= current_status_word_r;
		end
	end

	// ****************
	// Program counter and fetch
	// ****************
	always_ff @(posedge clk) begin
		if (reset) begin
			program_counter_r <= bcrsc_pkg::VEC_RESET;
		end else if (exc != bcrsc_pkg::BCRSC_EX_NONE) begin
			program_counter_r <= exc_vec;
		end else if (op_valid && !stall && (op_branch_exchange || op_branch_link_exchange
			|| op_branch_with_link || op_branch_to_bytecode || op_exc_return
			|| (op_is_load && op_rd == 4'hF))) begin
			program_counter_r <= {op_target[31:1], 1'b0};
		end else if (!stall) begin
			case (state_r)
				bcrsc_pkg::BCRSC_ST_COMPACT: program_counter_r <= program_counter_r + 32'h2;
				bcrsc_pkg::BCRSC_ST_BYTECODE: program_counter_r <= program_counter_r + 32'h1;
				default: program_counter_r <= program_counter_r + 32'h4;
			endcase
		end
	end

	// Bytecode fetches whole words
	always_ff @(posedge clk) begin
		if (reset) begin
			fetch_addr <= 32'h0000_0000;
			fetch_size <= bcrsc_pkg::SIZE_WORD;
		end else begin
			case (state_r)
				bcrsc_pkg::BCRSC_ST_COMPACT: begin
					fetch_addr <= {program_counter_r[31:1], 1'b0};
					fetch_size <= bcrsc_pkg::SIZE_HALF;
				end
				default: begin
					fetch_addr <= {program_counter_r[31:2], 2'h0};
					fetch_size <= bcrsc_pkg::SIZE_WORD;
				end
			endcase
		end
	end

	// Data access alignment check
	assign mem_misaligned = mem_req && ((mem_size == bcrsc_pkg::SIZE_WORD && mem_addr[1:0] != 2'h0)
		|| (mem_size == bcrsc_pkg::SIZE_HALF && mem_addr[0]));

	// ****************
	// Pipeline tracking and hazards
	// ****************
	// Bytecode decode holds an op one extra cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			bc_dec_cnt_r <= 2'h0;
		end else if (op_valid && state_r == bcrsc_pkg::BCRSC_ST_BYTECODE
			&& bc_dec_cnt_r < bcrsc_pkg::BC_DECODE_CYCLES - 2'h1) begin
			bc_dec_cnt_r <= bc_dec_cnt_r + 2'h1;
		end else begin
			bc_dec_cnt_r <= 2'h0;
		end
	end

	// Load data is late: load-use stalls once
	assign stall = (op_valid && state_r == bcrsc_pkg::BCRSC_ST_BYTECODE
		&& bc_dec_cnt_r == 2'h0)
		|| (op_valid && ex_load_r && ex_wr_r && (ex_rd_r == op_rn || ex_rd_r == op_rm));

	always_ff @(posedge clk) begin
		if (reset) begin
			ex_wr_r <= 1'b0;
			mem_wr_r <= 1'b0;
			ex_load_r <= 1'b0;
			ex_rd_r <= 4'h0;
			mem_rd_r <= 4'h0;
			ex_val_r <= 32'h0000_0000;
			mem_val_r <= 32'h0000_0000;
			pipe_stage_valid <= 3'h0;
		end else begin
			// Execute, memory, writeback occupancy
			ex_wr_r <= op_valid && !stall && op_writes_rd && exc == bcrsc_pkg::BCRSC_EX_NONE;
			ex_load_r <= op_valid && !stall && op_is_load;
			ex_rd_r <= op_rd;
			ex_val_r <= op_result;
			mem_wr_r <= ex_wr_r;
			mem_rd_r <= ex_rd_r;
			mem_val_r <= ex_val_r;
			pipe_stage_valid <= {pipe_stage_valid[1:0], op_valid && !stall};
		end
	end

	// Forward newest in-flight result
	always_comb begin
		operand_a = rf.rd_a_data;
		operand_b = rf.rd_b_data;
		if (op_rn == 4'hF) operand_a = program_counter_r;
		else if (ex_wr_r && ex_rd_r == op_rn) operand_a = ex_val_r;
		else if (mem_wr_r && mem_rd_r == op_rn) operand_a = mem_val_r;
		if (op_rm == 4'hF) operand_b = program_counter_r;
		else if (ex_wr_r && ex_rd_r == op_rm) operand_b = ex_val_r;
		else if (mem_wr_r && mem_rd_r == op_rm) operand_b = mem_val_r;
	end

	// Compact ops reach only r0-r7, sp, lr, pc
	assign op_illegal_reg = op_valid && state_r == bcrsc_pkg::BCRSC_ST_COMPACT
		&& ((op_rd[3] && op_rd < 4'hD) || (op_rn[3] && op_rn < 4'hD)
		|| (op_rm[3] && op_rm < 4'hD));

	// ****************
	// Register bank hookup
	// ****************
	assign rf.mode = mode;
	assign rf.rd_a_idx = op_rn;
	assign rf.rd_b_idx = op_rm;
	assign rf.wr_en = mem_wr_r;
	assign rf.wr_idx = mem_rd_r;
	assign rf.wr_data = mem_val_r;
	// Exceptions link in the entered mode
	assign rf.link_en = (exc != bcrsc_pkg::BCRSC_EX_NONE)
		|| (op_valid && !stall && (op_branch_with_link || op_branch_link_exchange));
	assign rf.link_mode = (exc != bcrsc_pkg::BCRSC_EX_NONE) ? exc_mode : mode;
	assign rf.link_data = link_ret;

	bcrsc_bank u_bank (
		.clk(clk),
		.reset(reset),
		.rf(rf)
	);

endmodule

// ### bench/bcrsc_irq_model.sv
`timescale 1ns/1ps
module bcrsc_irq_model (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Requests from the bench
	input wire logic req_fast,
	input wire logic req_norm,
	input wire logic serviced,
	// Interrupt lines
	output logic fast_irq,
	output logic normal_irq
);
	// Held until serviced
	always_ff @(posedge clk) begin
		if (reset || serviced) begin
			fast_irq <= 1'b0;
			normal_irq <= 1'b0;
		end else begin
			fast_irq <= fast_irq | req_fast;
			normal_irq <= normal_irq | req_norm;
		end
	end
endmodule

// ### bench/bcrsc_chk.sv
`timescale 1ns/1ps
module bcrsc_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Inputs
	input wire logic op_valid,
	input wire logic [3:0] op_rn,
	input wire logic op_status_write,
	input wire logic op_swi,
	input wire logic op_undef,
	input wire logic fast_irq,
	input wire logic normal_irq,
	input wire logic data_abort,
	input wire logic prefetch_abort,
	input wire logic mem_req,
	input wire logic [31:0] mem_addr,
	input wire logic [1:0] mem_size,
	// Outputs
	input wire logic mem_misaligned,
	input wire logic [1:0] fetch_size,
	input wire logic stall,
	input wire logic [31:0] current_status_word,
	input wire logic [31:0] saved_status_word,
	input wire logic privileged,
	input wire logic op_illegal_reg
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	logic [4:0] md;
	logic cpt, bct, quiet, take;
	assign md = current_status_word[4:0];
	assign cpt = current_status_word[5];
	assign bct = current_status_word[24];
	// Exceptions override the op
	assign quiet = !fast_irq && !normal_irq && !data_abort && !prefetch_abort;
	assign take = op_valid && !stall;
	a_reset_state: assert property ($fell(reset) |-> md == bcrsc_pkg::MODE_SUPER
		&& !cpt && !bct && fetch_size == bcrsc_pkg::SIZE_WORD) else $error("reset state");
	a_priv_map: assert property (privileged == (md != bcrsc_pkg::MODE_USER))
		else $error("privilege");
	a_user_lock: assert property (take && op_status_write && !op_swi && !op_undef && quiet
		&& md == bcrsc_pkg::MODE_USER |=> md == bcrsc_pkg::MODE_USER) else $error("user mode left");
	a_abort_entry: assert property (data_abort |=> md == bcrsc_pkg::MODE_ABORT && !cpt && !bct)
		else $error("abort entry");
	a_status_saved: assert property (data_abort |=> saved_status_word == $past(current_status_word))
		else $error("status not saved");
	a_swi_entry: assert property (take && op_swi && !op_undef && quiet
		|=> md == bcrsc_pkg::MODE_SUPER && !cpt && !bct) else $error("swi entry");
	a_bc_fetch: assert property (bct && $past(bct) |-> fetch_size == bcrsc_pkg::SIZE_WORD)
		else $error("bytecode fetch");
	a_cp_fetch: assert property (cpt && $past(cpt) |-> fetch_size == bcrsc_pkg::SIZE_HALF)
		else $error("compact fetch");
	a_bc_stall: assert property (op_valid && bct && !$past(stall) |-> stall)
		else $error("bytecode stall");
	a_misalign_flag: assert property (mem_req |-> mem_misaligned ==
		((mem_size == bcrsc_pkg::SIZE_HALF && mem_addr[0])
		|| (mem_size == bcrsc_pkg::SIZE_WORD && mem_addr[1:0] != 2'h0)))
		else $error("alignment flag");
	a_compact_regs: assert property (op_valid && cpt && op_rn inside {[4'h8:4'hC]}
		|-> op_illegal_reg) else $error("high register");
	cover property ($rose(bct));
	cover property ($rose(cpt));
	cover property (take && op_swi);
endmodule
bind bcrsc_core bcrsc_chk u_chk (.clk, .reset, .op_valid, .op_rn, .op_status_write, .op_swi,
	.op_undef, .fast_irq, .normal_irq, .data_abort, .prefetch_abort, .mem_req, .mem_addr,
	.mem_size, .mem_misaligned, .fetch_size, .stall, .current_status_word, .saved_status_word,
	.privileged, .op_illegal_reg);

// ### bench/banked_core_register_state_control_tb.sv
`timescale 1ns/1ps
module banked_core_register_state_control_tb;
	// ****************
	// Signals
	// ****************
	localparam int K_WR = 1, K_SW = 2, K_BX = 3, K_BLX = 4, K_BJ = 6, K_LD = 7;
	localparam int K_RET = 8, K_SWI = 9, K_UND = 10, K_PAB = 11, K_BL = 5;
	localparam int S_MODE = 0, S_SMODE = 1, S_ST = 2, S_SST = 3, S_FSZ = 4;
	localparam int S_PRIV = 5, S_A = 6, S_STALL = 7, S_ILL = 8, S_MIS = 9;
	typedef struct {int sel; logic [31:0] exp;} bcrsc_note_t;
	logic clk, reset, op_valid, op_writes_rd, op_is_load, op_branch_exchange;
	logic op_branch_link_exchange, op_branch_with_link, op_branch_to_bytecode, op_status_write;
	logic op_exc_return, op_swi, op_undef, data_abort, prefetch_abort, mem_req;
	logic fast_irq, normal_irq, req_fast, req_norm, serviced;
	logic mem_misaligned, stall, privileged, op_illegal_reg;
	logic [3:0] op_rd, op_rn, op_rm;
	logic [1:0] mem_size, fetch_size, sz;
	logic [2:0] pipe_stage_valid;
	logic [31:0] op_result, op_target, op_status_data, mem_addr, fetch_addr, rs, ea;
	logic [31:0] operand_a, operand_b, current_status_word, saved_status_word;
	logic [31:0] v [4];
	int kk [4] = '{K_BLX, K_BX, K_LD, K_LD};
	logic [31:0] tg [4] = '{32'h0000_0101, 32'h0000_0200, 32'h0000_0301, 32'h0000_0400};
	int err_total, checked;
	bcrsc_note_t notes [$];
	bcrsc_note_t n;

	bcrsc_core DUT (.clk, .reset, .op_valid, .op_rd, .op_rn, .op_rm, .op_writes_rd, .op_result,
		.op_is_load, .op_branch_exchange, .op_branch_link_exchange, .op_branch_with_link,
		.op_branch_to_bytecode, .op_target, .op_status_write, .op_status_data, .op_exc_return,
		.op_swi, .op_undef, .fast_irq, .normal_irq, .data_abort, .prefetch_abort, .mem_req,
		.mem_addr, .mem_size, .mem_misaligned, .fetch_addr, .fetch_size, .operand_a, .operand_b,
		.stall, .current_status_word, .saved_status_word, .privileged, .pipe_stage_valid,
		.op_illegal_reg);
	bcrsc_irq_model u_irq (.clk, .reset, .req_fast, .req_norm, .serviced, .fast_irq, .normal_irq);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ****************
	// Helpers
	// ****************
	function automatic logic [31:0] xs(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		xs = y ^ (y << 5);
	endfunction

	function automatic logic [31:0] obs(input int s);
		case (s)
			S_MODE: obs = {27'h0, current_status_word[4:0]};
			S_SMODE: obs = {27'h0, saved_status_word[4:0]};
			S_ST: obs = {30'h0, current_status_word[24], current_status_word[5]};
			S_SST: obs = {30'h0, saved_status_word[24], saved_status_word[5]};
			S_FSZ: obs = {30'h0, fetch_size};
			S_PRIV: obs = {31'h0, privileged};
			S_A: obs = operand_a;
			S_STALL: obs = {31'h0, stall};
			S_ILL: obs = {31'h0, op_illegal_reg};
			default: obs = {31'h0, mem_misaligned};
		endcase
	endfunction

	task give_verdict;
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task note(input int s, input logic [31:0] e);
		notes.push_back('{s, e});
	endtask

	task nmode(input logic [4:0] m);
		note(S_MODE, {27'h0, m});
	endtask

	task tmo(input int w);
		if (w >= 20) begin
			err_total++;
			give_verdict;
		end
	endtask

	// c: stall check, stall, operand, flag
	task op(input int k, input logic [3:0] rd, rn, input logic [31:0] d, input logic [3:0] c);
		int w;
		@(posedge clk);
		op_valid <= 1'b1;
		op_rd <= rd;
		op_rn <= rn;
		op_rm <= {1'b0, rs[2:0]};
		op_writes_rd <= k == K_WR || k == K_LD;
		op_result <= d;
		op_target <= d;
		op_status_data <= d;
		op_is_load <= k == K_LD;
		op_status_write <= k == K_SW;
		op_branch_exchange <= k == K_BX;
		op_branch_link_exchange <= k == K_BLX;
		op_branch_with_link <= k == K_BL;
		op_branch_to_bytecode <= k == K_BJ;
		op_exc_return <= k == K_RET;
		op_swi <= k == K_SWI;
		op_undef <= k == K_UND;
		prefetch_abort <= k == K_PAB;
		if (c[0]) note(S_STALL, {31'h0, c[1]});
		if (c[2]) note(S_A, ea);
		if (c[3]) note(S_ILL, 32'h0000_0001);
		w = 0;
		do begin
			@(negedge clk);
			w++;
		end while (stall !== 1'b0 && w < 20);
		tmo(w);
	endtask

	task idle;
		@(posedge clk);
		op_valid <= 1'b0;
		data_abort <= 1'b0;
		mem_req <= 1'b0;
	endtask

	task rdreg(input logic [3:0] r, input logic [31:0] e);
		@(posedge clk);
		op_rn <= r;
		note(S_A, e);
	endtask

	task irq(input logic f, input logic [4:0] m);
		int w;
		@(posedge clk);
		req_fast <= f;
		req_norm <= !f;
		@(posedge clk);
		{req_fast, req_norm} <= 2'h0;
		w = 0;
		do begin
			@(negedge clk);
			w++;
		end while (current_status_word[4:0] !== m && w < 20);
		tmo(w);
		@(posedge clk);
		serviced <= 1'b1;
		note(S_ST, 32'h0);
		@(posedge clk);
		serviced <= 1'b0;
	endtask

	always @(negedge clk) begin
		while (notes.size() > 0) begin
			n = notes.pop_front();
			checked++;
			if (obs(n.sel) !== n.exp) begin
				err_total++;
				$display("wrong value %0t got %h exp %h", $time, obs(n.sel), n.exp);
			end
		end
	end

	initial begin
		#500000;
		err_total++;
		give_verdict;
	end

	// ****************
	// Scenarios
	// ****************
	initial begin
		rs = 32'h0000_002C;
		err_total = 0;
		checked = 0;
		reset = 1'b1;
		ea = 32'h0;
		{op_valid, op_writes_rd, op_is_load, op_branch_exchange, op_branch_link_exchange} = '0;
		{op_branch_with_link, op_branch_to_bytecode, op_status_write, op_exc_return} = '0;
		{op_swi, op_undef, data_abort, prefetch_abort, mem_req, req_fast, req_norm, serviced} = '0;
		{op_rd, op_rn, op_rm, mem_size, op_result, op_target, op_status_data, mem_addr} = '0;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		nmode(bcrsc_pkg::MODE_SUPER);
		note(S_ST, 32'h0);
		note(S_PRIV, 32'h0000_0001);
		for (int i = 0; i < 4; i++) begin
			rs = xs(rs);
			v[i] = rs;
		end
		// Writes retire before a mode change so they land in the issuing bank
		op(K_WR, 4'h1, 4'h0, v[0], 4'h0);
		op(K_WR, 4'hD, 4'h0, v[1], 4'h0);
		idle;
		op(K_SW, 4'h0, 4'h0, {27'h0, bcrsc_pkg::MODE_USER}, 4'h0);
		op(K_WR, 4'hD, 4'h0, v[2], 4'h0);
		op(K_WR, 4'h8, 4'h0, v[3], 4'h0);
		op(K_SW, 4'h0, 4'h0, {5'h1F, 22'h0, bcrsc_pkg::MODE_SUPER}, 4'h0);
		idle;
		nmode(bcrsc_pkg::MODE_USER);
		note(S_PRIV, 32'h0);
		op(K_SWI, 4'h0, 4'h0, 32'h0, 4'h0);
		idle;
		nmode(bcrsc_pkg::MODE_SUPER);
		note(S_SMODE, {27'h0, bcrsc_pkg::MODE_USER});
		rdreg(4'hD, v[1]);
		rdreg(4'h8, v[3]);
		rdreg(4'h1, v[0]);
		op(K_SW, 4'h0, 4'h0, {27'h0, bcrsc_pkg::MODE_FAST}, 4'h0);
		idle;
		rdreg(4'h8, 32'h0);
		rdreg(4'hD, 32'h0);
		op(K_WR, 4'h8, 4'h0, v[0], 4'h0);
		idle;
		op(K_SW, 4'h0, 4'h0, {27'h0, bcrsc_pkg::MODE_SYSTEM}, 4'h0);
		idle;
		rdreg(4'h8, v[3]);
		rdreg(4'hD, v[2]);
		note(S_PRIV, 32'h0000_0001);
		// Forward, then load-use stall
		op(K_WR, 4'h2, 4'h0, v[1], 4'h0);
		ea = v[1];
		op(K_WR, 4'h5, 4'h2, v[0], 4'h5);
		op(K_LD, 4'h3, 4'h0, v[2], 4'h0);
		op(K_WR, 4'h6, 4'h3, v[0], 4'h3);
		for (int i = 0; i < 4; i++) begin
			op(kk[i], 4'hF, 4'h0, tg[i], 4'h0);
			idle;
			note(S_ST, {31'h0, tg[i][0]});
		end
		op(K_BX, 4'hF, 4'h0, 32'h0000_0501, 4'h0);
		op(K_WR, 4'h0, 4'h9, 32'h0, 4'h8);
		op(K_BJ, 4'hF, 4'h0, 32'h0000_0600, 4'h0);
		idle;
		note(S_ST, 32'h0000_0001);
		note(S_FSZ, {30'h0, bcrsc_pkg::SIZE_HALF});
		op(K_SWI, 4'h0, 4'h0, 32'h0, 4'h0);
		idle;
		note(S_ST, 32'h0);
		note(S_SST, 32'h0000_0001);
		op(K_RET, 4'hF, 4'h0, 32'h0000_0701, 4'h0);
		idle;
		note(S_ST, 32'h0000_0001);
		nmode(bcrsc_pkg::MODE_SYSTEM);
		op(K_BX, 4'hF, 4'h0, 32'h0000_0800, 4'h0);
		op(K_BJ, 4'hF, 4'h0, 32'h0000_0900, 4'h0);
		op(K_WR, 4'h7, 4'h0, 32'h0, 4'h3);
		op(K_BX, 4'hF, 4'h0, 32'h0000_0A01, 4'h0);
		idle;
		note(S_ST, 32'h0000_0002);
		note(S_FSZ, {30'h0, bcrsc_pkg::SIZE_WORD});
		irq(1'b0, bcrsc_pkg::MODE_IRQ);
		repeat (6) @(posedge clk);
		for (int i = 0; i < 3; i++) begin
			if (i == 0) begin
				@(posedge clk);
				data_abort <= 1'b1;
			end else begin
				op(i == 1 ? K_UND : K_PAB, 4'h0, 4'h0, 32'h0, 4'h0);
			end
			idle;
			nmode(i == 1 ? bcrsc_pkg::MODE_UNDEF : bcrsc_pkg::MODE_ABORT);
		end
		irq(1'b1, bcrsc_pkg::MODE_FAST);
		rdreg(4'h8, v[0]);
		for (int i = 0; i < 16; i++) begin
			rs = xs(rs);
			sz = rs[9:8] == 2'h3 ? 2'h2 : rs[9:8];
			@(posedge clk);
			mem_req <= 1'b1;
			mem_addr <= rs;
			mem_size <= sz;
			note(S_MIS, {31'h0, (sz == 2'h1 && rs[0]) || (sz == 2'h2 && rs[1:0] != 2'h0)});
		end
		idle;
		repeat (2) @(posedge clk);
		give_verdict;
	end
endmodule
